// [common/ulrp_defs.svh]
`ifndef ULRP_DEFS_SVH
`define ULRP_DEFS_SVH

// register byte offsets
`define ULRP_OFF_CTRL 8'h00
`define ULRP_OFF_CMD 8'h04
`define ULRP_OFF_LBA 8'h08
`define ULRP_OFF_COUNT 8'h0C
`define ULRP_OFF_WDATA 8'h10
`define ULRP_OFF_LOCK 8'h14
`define ULRP_OFF_STATUS 8'h18
`define ULRP_OFF_CAP 8'h1C
`define ULRP_OFF_RDATA 8'h20
`define ULRP_OFF_RPI 8'h24
`define ULRP_OFF_RFLAGS 8'h28
`define ULRP_OFF_IRQ_STAT 8'h2C
`define ULRP_OFF_IRQ_MASK 8'h30

// field positions
`define ULRP_CTRL_PI_EN 0
`define ULRP_CMD_OP_LSB 0
`define ULRP_CMD_RDP_LSB 4
`define ULRP_CMD_IP 8
`define ULRP_ST_BUSY 0
`define ULRP_ST_FULL_PROV 1
`define ULRP_ST_LBPME 2
`define ULRP_ST_LBPRZ 3
`define ULRP_ST_SED 4
`define ULRP_ST_PI_EN 5
`define ULRP_FL_DATA_VALID 0
`define ULRP_FL_PI_VALID 1
`define ULRP_FL_PI_ERR 2
`define ULRP_FL_MAPPED 3
`define ULRP_IRQ_DONE 0
`define ULRP_IRQ_PI_ERR 1
`define ULRP_IRQ_REJECT 2

// values
`define ULRP_PI_STD 32'hFFFFFFFF
`define ULRP_ZERO 32'h00000000
`define ULRP_SEED_RST 32'h5A5A1234
`define ULRP_LFSR_RST 32'hACE1ACE1
`define ULRP_LFSR_TAPS 32'h80200003
`define ULRP_MIX_A 32'h9E3779B9
`define ULRP_MIX_B 32'h85EBCA6B
`define ULRP_MIX_C 32'hC2B2AE35

`endif

// [common/ulrp_pkg.sv]
package ulrp_pkg;

   typedef enum logic [2:0] {
      ULRP_OP_READ = 3'h0,
      ULRP_OP_WRITE = 3'h1,
      ULRP_OP_UNMAP = 3'h2,
      ULRP_OP_ERASE = 3'h3,
      ULRP_OP_SETCAP = 3'h4,
      ULRP_OP_FORMAT = 3'h5
   } ulrp_op_t;

   typedef enum logic [2:0] {
      ULRP_ST_IDLE = 3'b001,
      ULRP_ST_WALK = 3'b010,
      ULRP_ST_READ = 3'b100
   } ulrp_state_t;

endpackage

// [common/ulrp_core_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface ulrp_core_if #(parameter int LBA_W = 8);
   logic [LBA_W-1:0] addr;
   logic wr_en;
   logic unmap_en;
   logic [31:0] wdata;
   logic mapped;
   logic [31:0] rdata;
   logic [31:0] seed;
   logic [31:0] scr_data;
   logic [31:0] scr_pi;

   modport ctl (output addr, output wr_en, output unmap_en, output wdata,
      output seed, input mapped, input rdata, input scr_data,
      input scr_pi);
   modport map (input addr, input wr_en, input unmap_en, input wdata,
      output mapped, output rdata);
   modport scr (input addr, input seed, output scr_data, output scr_pi);
endinterface
`default_nettype wire

// [verilog/ulrp_map.sv]
`timescale 1ns/1ps
`default_nettype none
module ulrp_map #(
   parameter int NUM_LBA = 256
) (
   input wire logic hclk,
   input wire logic hresetn,
   ulrp_core_if.map core
);
   logic mapped_reg [NUM_LBA];
   logic [31:0] data_mem [NUM_LBA];

   // map state needs reset: every block starts out unmapped
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < NUM_LBA; i++) begin
            mapped_reg[i] <= 1'b0;
         end
      end else if (core.wr_en) begin
         mapped_reg[core.addr] <= 1'b1;
      end else if (core.unmap_en) begin
         mapped_reg[core.addr] <= 1'b0;
      end
   end

   // user data has no reset; it is never shown while unmapped
   always_ff @(posedge hclk) begin
      if (core.wr_en) begin
         data_mem[core.addr] <= core.wdata;
      end
   end

   assign core.mapped = mapped_reg[core.addr];
   assign core.rdata = data_mem[core.addr];
endmodule
`default_nettype wire

// [verilog/ulrp_scrambler.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ulrp_defs.svh"
module ulrp_scrambler (
   ulrp_core_if.scr core
);
   logic [31:0] base;
   logic [31:0] mix_d;
   logic [31:0] mix_p;

   // pure function of address and band seed, so repeat reads agree
   always_comb begin
      base = core.seed ^ (32'(core.addr) * `ULRP_MIX_A);
      mix_d = base ^ (base >> 16);
      mix_d = mix_d * `ULRP_MIX_B;
      mix_d = mix_d ^ (mix_d >> 13);
      mix_p = ~base ^ (base >> 15);
      mix_p = mix_p * `ULRP_MIX_C;
      mix_p = mix_p ^ (mix_p >> 16);
   end

   assign core.scr_data = mix_d;
   assign core.scr_pi = mix_p;
endmodule
`default_nettype wire

// [verilog/ulrp_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ulrp_defs.svh"
module ulrp_top #(
   parameter int NUM_LBA = 256,
   parameter int NUM_BANDS = 4,
   parameter bit SED = 1'b1
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   output logic irq
);
   localparam int LBA_W = $clog2(NUM_LBA);
   localparam int CAP_W = LBA_W + 1;
   localparam int BAND_W = $clog2(NUM_BANDS);
   localparam logic [CAP_W-1:0] MAX_CAP = CAP_W'(NUM_LBA);

   ulrp_core_if #(.LBA_W(LBA_W)) core ();

   ulrp_map #(.NUM_LBA(NUM_LBA)) u_map (
      .hclk(hclk),
      .hresetn(hresetn),
      .core(core.map)
   );

   ulrp_scrambler u_scr (
      .core(core.scr)
   );

   // bus phase tracking
   logic dph_wr_reg, dph_wr_next;
   logic [7:0] dph_addr_reg, dph_addr_next;
   logic [31:0] hrdata_reg, hrdata_next;
   logic take, addr_ok;
   logic [31:0] rd_mux;

   // software registers
   logic pi_en_reg, pi_en_next;
   logic [NUM_BANDS-1:0] lock_reg, lock_next;
   logic [31:0] lba_reg, lba_next;
   logic [31:0] cnt_reg, cnt_next;
   logic [31:0] wdata_reg, wdata_next;
   logic [2:0] mask_reg, mask_next;
   logic [2:0] irq_stat_reg, irq_stat_next;

   // command engine
   ulrp_pkg::ulrp_state_t state_reg, state_next;
   logic [LBA_W-1:0] cur_reg, cur_next;
   logic [LBA_W-1:0] last_reg, last_next;
   logic walk_wr_reg, walk_wr_next;
   logic [2:0] rdp_reg, rdp_next;
   logic [CAP_W-1:0] cap_reg, cap_next;
   logic full_prov_reg, full_prov_next;
   logic [31:0] res_data_reg, res_data_next;
   logic [31:0] res_pi_reg, res_pi_next;
   logic [3:0] flags_reg, flags_next;
   logic [31:0] lfsr_reg, lfsr_next;
   logic [31:0] seed_reg [NUM_BANDS];
   logic [31:0] seed_next [NUM_BANDS];
   logic ev_done, ev_pi_err, ev_reject;
   logic erase_go;
   logic [BAND_W-1:0] erase_band;

   logic wr_hit, cmd_go;
   ulrp_pkg::ulrp_op_t cmd_op;
   logic [32:0] unmap_end;
   logic [BAND_W-1:0] band_lo, band_hi;
   logic [NUM_BANDS-1:0] band_hit;
   logic range_locked;
   logic [CAP_W-1:0] new_cap;

   assign take = hsel & hready & htrans[1];
   assign addr_ok = (haddr[31:8] == 24'h000000);
   assign wr_hit = dph_wr_reg;
   assign cmd_go = wr_hit && (dph_addr_reg == `ULRP_OFF_CMD);
   assign cmd_op = ulrp_pkg::ulrp_op_t'(hwdata[`ULRP_CMD_OP_LSB +: 3]);
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_reg;
   assign irq = |(irq_stat_reg & mask_reg);

   always_comb begin
      rd_mux = `ULRP_ZERO;
      unique case (haddr[7:0])
         `ULRP_OFF_CTRL: rd_mux[`ULRP_CTRL_PI_EN] = pi_en_reg;
         `ULRP_OFF_LBA: rd_mux = lba_reg;
         `ULRP_OFF_COUNT: rd_mux = cnt_reg;
         `ULRP_OFF_WDATA: rd_mux = wdata_reg;
         `ULRP_OFF_LOCK: rd_mux[NUM_BANDS-1:0] = lock_reg;
         `ULRP_OFF_STATUS: begin
            rd_mux[`ULRP_ST_BUSY] = (state_reg != ulrp_pkg::ULRP_ST_IDLE);
            rd_mux[`ULRP_ST_FULL_PROV] = full_prov_reg;
            rd_mux[`ULRP_ST_LBPME] = 1'b1;
            rd_mux[`ULRP_ST_LBPRZ] = ~SED;
            rd_mux[`ULRP_ST_SED] = SED;
            rd_mux[`ULRP_ST_PI_EN] = pi_en_reg;
         end
         `ULRP_OFF_CAP: rd_mux[CAP_W-1:0] = cap_reg;
         `ULRP_OFF_RDATA: rd_mux = res_data_reg;
         `ULRP_OFF_RPI: rd_mux = res_pi_reg;
         `ULRP_OFF_RFLAGS: rd_mux[3:0] = flags_reg;
         `ULRP_OFF_IRQ_STAT: rd_mux[2:0] = irq_stat_reg;
         `ULRP_OFF_IRQ_MASK: rd_mux[2:0] = mask_reg;
         default: rd_mux = `ULRP_ZERO;
      endcase
   end

   always_comb begin
      dph_wr_next = take & hwrite & addr_ok;
      dph_addr_next = take ? haddr[7:0] : dph_addr_reg;
      hrdata_next = hrdata_reg;
      if (take && !hwrite) begin
         hrdata_next = addr_ok ? rd_mux : `ULRP_ZERO;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_wr_reg <= 1'b0;
         dph_addr_reg <= 8'h00;
         hrdata_reg <= `ULRP_ZERO;
      end else begin
         dph_wr_reg <= dph_wr_next;
         dph_addr_reg <= dph_addr_next;
         hrdata_reg <= hrdata_next;
      end
   end

   // software register writes and sticky events
   always_comb begin
      pi_en_next = pi_en_reg;
      lock_next = lock_reg;
      lba_next = lba_reg;
      cnt_next = cnt_reg;
      wdata_next = wdata_reg;
      mask_next = mask_reg;
      irq_stat_next = irq_stat_reg;
      if (wr_hit) begin
         unique case (dph_addr_reg)
            `ULRP_OFF_CTRL: pi_en_next = hwdata[`ULRP_CTRL_PI_EN];
            `ULRP_OFF_LBA: lba_next = hwdata;
            `ULRP_OFF_COUNT: cnt_next = hwdata;
            `ULRP_OFF_WDATA: wdata_next = hwdata;
            `ULRP_OFF_LOCK: lock_next = hwdata[NUM_BANDS-1:0];
            `ULRP_OFF_IRQ_MASK: mask_next = hwdata[2:0];
            `ULRP_OFF_IRQ_STAT: irq_stat_next = irq_stat_reg & ~hwdata[2:0];
            default: ;
         endcase
      end
      // a new event beats a clear in the same cycle
      irq_stat_next = irq_stat_next | {ev_reject, ev_pi_err, ev_done};
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pi_en_reg <= 1'b0;
         lock_reg <= '0;
         lba_reg <= `ULRP_ZERO;
         cnt_reg <= `ULRP_ZERO;
         wdata_reg <= `ULRP_ZERO;
         mask_reg <= 3'h0;
         irq_stat_reg <= 3'h0;
      end else begin
         pi_en_reg <= pi_en_next;
         lock_reg <= lock_next;
         lba_reg <= lba_next;
         cnt_reg <= cnt_next;
         wdata_reg <= wdata_next;
         mask_reg <= mask_next;
         irq_stat_reg <= irq_stat_next;
      end
   end

   assign unmap_end = {1'b0, lba_reg} + {1'b0, cnt_reg} - 33'h000000001;
   assign band_lo = lba_reg[LBA_W-1 -: BAND_W];
   assign band_hi = unmap_end[LBA_W-1 -: BAND_W];
   assign erase_band = lba_reg[BAND_W-1:0];
   assign new_cap = (cnt_reg >= 32'(NUM_LBA)) ? MAX_CAP : cnt_reg[CAP_W-1:0];

   genvar b;
   generate
      for (b = 0; b < NUM_BANDS; b++) begin : g_band
         assign band_hit[b] = (band_lo <= BAND_W'(b)) &&
            (BAND_W'(b) <= band_hi);
         // erase gives the band a fresh seed
         always_comb begin
            seed_next[b] = seed_reg[b];
            if (erase_go && erase_band == BAND_W'(b)) begin
               seed_next[b] = lfsr_reg;
            end
         end
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               seed_reg[b] <= `ULRP_SEED_RST ^ 32'(b);
            end else begin
               seed_reg[b] <= seed_next[b];
            end
         end
      end
   endgenerate

   // any locked band in the range blocks the unmap
   assign range_locked = |(band_hit & lock_reg);

   assign core.addr = cur_reg;
   assign core.wdata = wdata_reg;
   assign core.wr_en = (state_reg == ulrp_pkg::ULRP_ST_WALK) & walk_wr_reg;
   assign core.unmap_en = (state_reg == ulrp_pkg::ULRP_ST_WALK) &
      ~walk_wr_reg;
   assign core.seed = seed_reg[cur_reg[LBA_W-1 -: BAND_W]];

   always_comb begin
      state_next = state_reg;
      cur_next = cur_reg;
      last_next = last_reg;
      walk_wr_next = walk_wr_reg;
      rdp_next = rdp_reg;
      cap_next = cap_reg;
      full_prov_next = full_prov_reg;
      res_data_next = res_data_reg;
      res_pi_next = res_pi_reg;
      flags_next = flags_reg;
      lfsr_next = {lfsr_reg[30:0], 1'b0} ^
         (lfsr_reg[31] ? `ULRP_LFSR_TAPS : `ULRP_ZERO);
      ev_done = 1'b0;
      ev_pi_err = 1'b0;
      ev_reject = 1'b0;
      erase_go = 1'b0;
      unique case (state_reg)
         ulrp_pkg::ULRP_ST_IDLE: begin
            if (cmd_go) begin
               walk_wr_next = 1'b0;
               rdp_next = hwdata[`ULRP_CMD_RDP_LSB +: 3];
               unique case (cmd_op)
                  ulrp_pkg::ULRP_OP_READ,
                  ulrp_pkg::ULRP_OP_WRITE: begin
                     if (lba_reg >= 32'(cap_reg)) begin
                        ev_reject = 1'b1;
                     end else begin
                        cur_next = lba_reg[LBA_W-1:0];
                        last_next = lba_reg[LBA_W-1:0];
                        walk_wr_next = (cmd_op == ulrp_pkg::ULRP_OP_WRITE);
                        state_next = (cmd_op == ulrp_pkg::ULRP_OP_WRITE) ?
                           ulrp_pkg::ULRP_ST_WALK : ulrp_pkg::ULRP_ST_READ;
                     end
                  end
                  ulrp_pkg::ULRP_OP_UNMAP: begin
                     if (cnt_reg == `ULRP_ZERO) begin
                        ev_done = 1'b1;
                     end else if (unmap_end >= 33'(cap_reg) ||
                        range_locked) begin
                        ev_reject = 1'b1;
                     end else begin
                        cur_next = lba_reg[LBA_W-1:0];
                        last_next = unmap_end[LBA_W-1:0];
                        state_next = ulrp_pkg::ULRP_ST_WALK;
                     end
                  end
                  ulrp_pkg::ULRP_OP_ERASE: begin
                     if (lba_reg >= 32'(NUM_BANDS)) begin
                        ev_reject = 1'b1;
                     end else begin
                        // erase walks and unmaps the whole band
                        erase_go = 1'b1;
                        cur_next = {erase_band, {(LBA_W-BAND_W){1'b0}}};
                        last_next = {erase_band, {(LBA_W-BAND_W){1'b1}}};
                        state_next = ulrp_pkg::ULRP_ST_WALK;
                     end
                  end
                  ulrp_pkg::ULRP_OP_SETCAP: begin
                     if (cnt_reg == `ULRP_ZERO || new_cap == MAX_CAP) begin
                        cap_next = (cnt_reg == `ULRP_ZERO) ? cap_reg : MAX_CAP;
                        ev_done = 1'b1;
                     end else begin
                        cap_next = new_cap;
                        cur_next = new_cap[LBA_W-1:0];
                        last_next = {LBA_W{1'b1}};
                        state_next = ulrp_pkg::ULRP_ST_WALK;
                     end
                  end
                  ulrp_pkg::ULRP_OP_FORMAT: begin
                     // IP bit only sets full_prov_reg for STATUS; the walk unmaps every block either way
                     full_prov_next = hwdata[`ULRP_CMD_IP];
                     cur_next = {LBA_W{1'b0}};
                     last_next = {LBA_W{1'b1}};
                     state_next = ulrp_pkg::ULRP_ST_WALK;
                  end
                  default: ev_reject = 1'b1;
               endcase
            end else if (wr_hit && dph_addr_reg == `ULRP_OFF_CMD) begin
               ev_reject = 1'b1;
            end
         end
         ulrp_pkg::ULRP_ST_WALK: begin
            if (cmd_go) begin
               // one command at a time; extra ones are refused
               ev_reject = 1'b1;
            end
            if (cur_reg == last_reg) begin
               ev_done = 1'b1;
               state_next = ulrp_pkg::ULRP_ST_IDLE;
            end else begin
               cur_next = cur_reg + 1'b1;
            end
         end
         ulrp_pkg::ULRP_ST_READ: begin
            ev_reject = cmd_go;
            ev_done = 1'b1;
            state_next = ulrp_pkg::ULRP_ST_IDLE;
            res_data_next = `ULRP_ZERO;
            res_pi_next = `ULRP_ZERO;
            flags_next = 4'h0;
            flags_next[`ULRP_FL_MAPPED] = core.mapped;
            flags_next[`ULRP_FL_DATA_VALID] = 1'b1;
            flags_next[`ULRP_FL_PI_VALID] = pi_en_reg;
            if (core.mapped) begin
               res_data_next = core.rdata;
            end else if (!SED) begin
               res_pi_next = pi_en_reg ? `ULRP_PI_STD : `ULRP_ZERO;
            end else if (!pi_en_reg) begin
               res_data_next = core.scr_data;
            end else if (rdp_reg != 3'h0) begin
               flags_next[`ULRP_FL_DATA_VALID] = 1'b0;
               flags_next[`ULRP_FL_PI_VALID] = 1'b0;
               flags_next[`ULRP_FL_PI_ERR] = 1'b1;
               ev_pi_err = 1'b1;
            end else begin
               res_data_next = core.scr_data;
               res_pi_next = core.scr_pi;
            end
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= ulrp_pkg::ULRP_ST_IDLE;
         cur_reg <= '0;
         last_reg <= '0;
         walk_wr_reg <= 1'b0;
         rdp_reg <= 3'h0;
         cap_reg <= MAX_CAP;
         full_prov_reg <= 1'b0;
         res_data_reg <= `ULRP_ZERO;
         res_pi_reg <= `ULRP_ZERO;
         flags_reg <= 4'h0;
         lfsr_reg <= `ULRP_LFSR_RST;
      end else begin
         state_reg <= state_next;
         cur_reg <= cur_next;
         last_reg <= last_next;
         walk_wr_reg <= walk_wr_next;
         rdp_reg <= rdp_next;
         cap_reg <= cap_next;
         full_prov_reg <= full_prov_next;
         res_data_reg <= res_data_next;
         res_pi_reg <= res_pi_next;
         flags_reg <= flags_next;
         lfsr_reg <= lfsr_next;
      end
   end
endmodule
`default_nettype wire

// [verification/ulrp_top_props.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ulrp_defs.svh"
module ulrp_props #(
   parameter int NUM_LBA = 256,
   parameter bit SED = 1'b1
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   input wire logic irq
);
   logic rd_take;
   logic wr_take;
   logic [15:0] since_wr_reg;
   logic [15:0] since_wr_next;
   assign rd_take = hsel && hready && htrans[1] && !hwrite;
   assign wr_take = hsel && hready && htrans[1] && hwrite;
   // saturates so a long idle spell cannot wrap
   always_comb begin
      since_wr_next = since_wr_reg;
      if (wr_take)
         since_wr_next = 16'h0000;
      else if (since_wr_reg != 16'hFFFF)
         since_wr_next = since_wr_reg + 16'h0001;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         since_wr_reg <= 16'h0000;
      else
         since_wr_reg <= since_wr_next;
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   AST_READY: assert property (hreadyout) else $error("hreadyout low");
   AST_OKAY: assert property (!hresp) else $error("hresp not okay");
   AST_HOLD: assert property (!rd_take |=> $stable(hrdata))
      else $error("hrdata moved without a read");
   AST_LBPME: assert property (
      rd_take && haddr == {24'h000000, `ULRP_OFF_STATUS}
      |=> hrdata[`ULRP_ST_LBPME]) else $error("lbpme not set");
   AST_LBPRZ: assert property (
      rd_take && haddr == {24'h000000, `ULRP_OFF_STATUS}
      |=> hrdata[`ULRP_ST_LBPRZ] == !SED && hrdata[`ULRP_ST_SED] == SED)
      else $error("lbprz or sed flag wrong");
   AST_HOLE: assert property (
      rd_take && (haddr[31:8] != 24'h000000 || haddr[7:0] > 8'h30)
      |=> hrdata == 32'h00000000) else $error("hole read nonzero");
   AST_PI_ERR: assert property (
      rd_take && haddr == {24'h000000, `ULRP_OFF_RFLAGS}
      |=> !hrdata[`ULRP_FL_PI_ERR] || (SED && !hrdata[`ULRP_FL_DATA_VALID]
      && !hrdata[`ULRP_FL_MAPPED])) else $error("pi error flag wrong");
   AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wr_take, 2))
      else $error("irq fell without a write");
   AST_IRQ_RISE: assert property ($rose(irq) |-> since_wr_reg <= NUM_LBA + 6)
      else $error("irq rose with no command");
   cover property ($rose(irq));
   cover property ($fell(irq));
   cover property (rd_take && haddr[7:0] == `ULRP_OFF_RFLAGS
      ##1 hrdata[`ULRP_FL_PI_ERR]);
endmodule
bind ulrp_top ulrp_props #(.NUM_LBA(NUM_LBA), .SED(SED)) props (
   .hclk(hclk),
   .hresetn(hresetn),
   .hsel(hsel),
   .haddr(haddr),
   .htrans(htrans),
   .hwrite(hwrite),
   .hready(hready),
   .hreadyout(hreadyout),
   .hrdata(hrdata),
   .hresp(hresp),
   .irq(irq)
);
`default_nettype wire

// [verification/ulrp_host.sv]
`timescale 1ns/1ps
`default_nettype none
module ulrp_host (
   input wire logic hclk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   output logic [31:0] rd_cnt,
   output logic [31:0] rd_dat
);
   initial begin
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      rd_cnt = 32'h00000000;
      rd_dat = 32'h00000000;
   end
   // entered just after a rising edge; a counter, not a pulse, flags reads
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (!hready) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (!hready) @(posedge hclk);
      q = hrdata;
      if (!w) begin
         rd_dat <= hrdata;
         rd_cnt <= rd_cnt + 32'h00000001;
      end
   endtask
endmodule
`default_nettype wire

// [verification/ulrp_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ulrp_defs.svh"
module ulrp_top_bench;
   typedef struct {
      string nm;
      logic [31:0] exp;
      logic [31:0] msk;
   } ulrp_note_t;
   localparam int N = 16;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel, hwrite, hready, hresp, irq;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, hrdata_rz, rd_cnt, rd_dat, lf, q, d0;
   int miscompares = 0;
   int n_checks = 0;
   int cyc = 0;
   int seen = 0;
   ulrp_note_t notes[$];
   always #2 hclk = ~hclk;
   ulrp_top #(.NUM_LBA(N), .NUM_BANDS(4), .SED(1'b1)) dut (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .irq(irq));
   // read-zeros build in lockstep on the same bus; only its read data is seen
   ulrp_top #(.NUM_LBA(N), .NUM_BANDS(4), .SED(1'b0)) dut_rz (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(), .hrdata(hrdata_rz), .hresp(), .irq());
   ulrp_host host (.hclk(hclk), .hready(hready), .hrdata(hrdata),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .rd_cnt(rd_cnt), .rd_dat(rd_dat));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string nm, input logic [31:0] s,
         input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic rd(input string nm, input logic [7:0] a,
         input logic [31:0] e, input logic [31:0] m);
      notes.push_back('{nm, e, m});
      host.xfer(1'b0, a, 32'h00000000, q);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, q);
   endtask
   task automatic cmd(input logic [2:0] op, input logic [2:0] rdp,
         input logic ip, input logic [31:0] stat);
      int n;
      n = 0;
      wr(`ULRP_OFF_CMD, {23'h000000, ip, 1'b0, rdp, 1'b0, op});
      while (irq !== 1'b1 && n < 100) begin
         @(negedge hclk);
         n++;
      end
      @(posedge hclk);
      chk("irq", {31'h00000000, irq}, 32'h00000001);
      rd("IRQ_STAT", `ULRP_OFF_IRQ_STAT, stat, 32'h00000007);
      wr(`ULRP_OFF_IRQ_STAT, 32'h00000007);
   endtask
   task automatic rdblk(input logic [31:0] lba, input logic [2:0] rdp,
         input logic [31:0] stat, input logic [31:0] fl);
      wr(`ULRP_OFF_LBA, lba);
      cmd(ulrp_pkg::ULRP_OP_READ, rdp, 1'b0, stat);
      rd("RFLAGS", `ULRP_OFF_RFLAGS, fl, 32'h0000000F);
   endtask
   task automatic wrblk(input logic [31:0] lba);
      lf = lfsr(lf);
      wr(`ULRP_OFF_LBA, lba);
      wr(`ULRP_OFF_WDATA, lf);
      cmd(ulrp_pkg::ULRP_OP_WRITE, 3'h0, 1'b0, 32'h00000001);
   endtask
   always @(posedge hclk) begin
      ulrp_note_t nt;
      if (rd_cnt != seen) begin
         seen = rd_cnt;
         nt = notes.pop_front();
         if (nt.msk != 32'h00000000)
            chk(nt.nm, rd_dat & nt.msk, nt.exp & nt.msk);
      end
   end
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         test_done();
      end
   end
   initial begin
      lf = 32'hC200;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd("STATUS", `ULRP_OFF_STATUS, 32'h00000014, 32'h0000003F);
      rd("CAP", `ULRP_OFF_CAP, N, 32'hFFFFFFFF);
      rd("HOLE", 8'h40, 32'h00000000, 32'hFFFFFFFF);
      wr(`ULRP_OFF_IRQ_MASK, 32'h00000007);
      rdblk(5, 3'h0, 32'h00000001, 32'h00000001);
      rd("RDATA", `ULRP_OFF_RDATA, 32'h00000000, 32'h00000000);
      d0 = q;
      chk("scramble", {31'h00000000, d0 === 32'h00000000}, 32'h0);
      rdblk(5, 3'h0, 32'h00000001, 32'h00000001);
      rd("RDATA", `ULRP_OFF_RDATA, d0, 32'hFFFFFFFF);
      wrblk(6);
      rdblk(6, 3'h0, 32'h00000001, 32'h00000009);
      rd("RDATA", `ULRP_OFF_RDATA, lf, 32'hFFFFFFFF);
      wr(`ULRP_OFF_LBA, 32'h00000001);
      cmd(ulrp_pkg::ULRP_OP_ERASE, 3'h0, 1'b0, 32'h00000001);
      rdblk(6, 3'h0, 32'h00000001, 32'h00000001);
      rdblk(5, 3'h0, 32'h00000001, 32'h00000001);
      rd("RDATA", `ULRP_OFF_RDATA, 32'h00000000, 32'h00000000);
      chk("reseed", {31'h00000000, q === d0}, 32'h0);
      chk("rz_data", hrdata_rz, `ULRP_ZERO);
      wrblk(3);
      wr(`ULRP_OFF_LOCK, 32'h00000002);
      wr(`ULRP_OFF_COUNT, 32'h00000002);
      cmd(ulrp_pkg::ULRP_OP_UNMAP, 3'h0, 1'b0, 32'h00000004);
      wr(`ULRP_OFF_COUNT, 32'h00000001);
      cmd(ulrp_pkg::ULRP_OP_UNMAP, 3'h0, 1'b0, 32'h00000001);
      rdblk(3, 3'h0, 32'h00000001, 32'h00000001);
      wr(`ULRP_OFF_LOCK, 32'h00000000);
      wr(`ULRP_OFF_CTRL, 32'h00000001);
      // every read-protect code, unmapped block with protection on
      for (int r = 0; r < 8; r++)
         rdblk(2, r[2:0], r ? 32'h3 : 32'h1, r ? 32'h4 : 32'h3);
      // error path leaves no PI; read-zeros build gives all-ones PI
      rd("RPI", `ULRP_OFF_RPI, `ULRP_ZERO, 32'hFFFFFFFF);
      chk("rz_pi", hrdata_rz, `ULRP_PI_STD);
      rdblk(2, 3'h0, 32'h00000001, 32'h00000003);
      rd("RPI", `ULRP_OFF_RPI, 32'h00000000, 32'h00000000);
      chk("scr_pi", {31'h00000000, q === 32'h00000000}, 32'h0);
      wrblk(1);
      // mapped read with protection on still flags the PI as valid
      rdblk(1, 3'h5, 32'h00000001, 32'h0000000B);
      wr(`ULRP_OFF_CTRL, 32'h00000000);
      wrblk(13);
      wr(`ULRP_OFF_COUNT, 32'h0000000C);
      cmd(ulrp_pkg::ULRP_OP_SETCAP, 3'h0, 1'b0, 32'h00000001);
      rd("CAP", `ULRP_OFF_CAP, 32'h0000000C, 32'hFFFFFFFF);
      // refused read leaves the previous result flags standing
      rdblk(13, 3'h0, 32'h00000004, 32'h0000000B);
      wr(`ULRP_OFF_COUNT, 32'h00000028);
      cmd(ulrp_pkg::ULRP_OP_SETCAP, 3'h0, 1'b0, 32'h00000001);
      rd("CAP", `ULRP_OFF_CAP, N, 32'hFFFFFFFF);
      rdblk(13, 3'h0, 32'h00000001, 32'h00000001);
      for (int ip = 1; ip >= 0; ip--) begin
         wrblk(0);
         cmd(ulrp_pkg::ULRP_OP_FORMAT, 3'h0, ip[0], 32'h00000001);
         rd("STATUS", `ULRP_OFF_STATUS, 32'h14 | (ip << 1), 32'h3F);
         rdblk(0, 3'h0, 32'h00000001, 32'h00000001);
      end
      repeat (3) @(posedge hclk);
      test_done();
   end
endmodule
`default_nettype wire
